/* File: smd_cfg.svh */
`ifndef SMD_CFG_SVH
`define SMD_CFG_SVH
// Notes on behaviour
// - Compatible window A0000-BFFFF maps to identical DRAM when enabled.
// - Enabled high window FEDA0000-FEDBFFFF remaps to DRAM A0000-BFFFF.
// - Top segment sits below top of low DRAM minus stolen; 1, 2 or 8 MB.
// - Global enable gates all; high replaces compatible; segment enable separate.
// - With high window on, compatible range goes to graphics, port or downstream by video bits.
// - Port and downstream sources never reach SMM space.
// - Unlocked and open allows code and data; closed denies outside SMM.
// - In SMM code is granted; data-close sends data to graphics, port or downstream.
// - Lock ignores open and denies all non-SMM access except write-backs.
// - Processor write-backs reach enabled SMM DRAM regardless of mode.
// - Translated graphics hits to SMM DRAM go to address 0 and set flag.
// - Port writes to aperture are snooped; reads go to 0 with UR.
// - Table fetches at or above segment base or 640K-1M go to 0.
// - Processor I/O inside base/limit goes to port, else downstream.
// - I/O addresses pass untranslated, bit 16 kept for wrap-around.
// - I/O writes are non-posted; memory writes to port or downstream posted.
// - Clearing port I/O enable stops I/O routing to the port.
// - Upstream I/O or configuration becomes a read of 0 with UR.
// - I/O read crossing a dword inside a qword is split in two.
// - Legacy video range: graphics first, then port by video bits, else downstream.
// - Non-SMM hits on the high window terminate, except write-backs or while open and unlocked.
`define SMD_COMPAT_LO 32'h000A_0000
`define SMD_COMPAT_HI 32'h000B_FFFF
`define SMD_HIGH_LO 32'hFEDA_0000
`define SMD_HIGH_HI 32'hFEDB_FFFF
`define SMD_MONO_LO 32'h000B_0000
`define SMD_MONO_HI 32'h000B_7FFF
`define SMD_LEGACY_HI 32'h000F_FFFF
`define SMD_SEG_1M 32'h0010_0000
`define SMD_SEG_2M 32'h0020_0000
`define SMD_SEG_8M 32'h0080_0000
`define SMD_NULL_ADDR 32'h0000_0000
`define SMD_DW_OFS 32'h0000_0004
`define SMD_REG_CTRL 8'h00
`define SMD_REG_MEMTOP 8'h04
`define SMD_REG_STOLEN 8'h08
`define SMD_REG_IOWIN 8'h0C
`define SMD_REG_PCMD 8'h10
`define SMD_REG_AP_LO 8'h14
`define SMD_REG_AP_HI 8'h18
`define SMD_REG_ERR 8'h1C
`define SMD_REG_STAT 8'h20
`define SMD_CTRL_GE 0
`define SMD_CTRL_HEN 1
`define SMD_CTRL_TEN 2
`define SMD_CTRL_OPEN 3
`define SMD_CTRL_CLS 4
`define SMD_CTRL_LCK 5
`define SMD_PCMD_IOEN 0
`define SMD_PCMD_VID 1
`define SMD_PCMD_MONO 2
`define SMD_PCMD_IGD 3
`define SMD_ERR_ITF 0
`define SMD_RST_CTRL 8'h00
`define SMD_RST_WORD 32'h0000_0000
`endif

/* File: smd_decoder.sv */
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "smd_cfg.svh"
module smd_decoder
    import smd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    output logic req_ready,
    input wire smd_src_t req_src,
    input wire smd_kind_t req_kind,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic [7:0] req_be,
    input wire logic req_smm,
    input wire logic req_code,
    input wire logic request_type_bit,
    output logic out_valid,
    input wire logic out_ready,
    output smd_tgt_t out_tgt,
    output logic [31:0] out_addr,
    output logic [3:0] out_be,
    output logic out_write,
    output logic out_ur,
    output logic out_posted,
    output logic out_snoop,
    output logic invalid_translation_flag
);
    smd_st_t s;
    smd_st_t next_s;
    logic hit_c;
    logic hit_h;
    logic hit_t;
    logic smm_dram;
    logic [31:0] seg_base;
    logic v_in;
    smd_tgt_t v_tgt;
    logic acc;
    logic mapped;
    logic [31:0] rdv;
    smd_tgt_t t;
    logic [31:0] a;
    logic [3:0] be;
    logic w;
    logic ur;
    logic snp;
    logic setf;
    logic split;
    logic grant;
    logic in_ap;
    logic io_hit;

    // Window decode on the live request address
    smd_window u_win (
        .addr(req_addr),
        .ctrl(s.ctrl),
        .memtop(s.memtop),
        .stolen(s.stolen),
        .seg_size(s.ctrl[7:6]),
        .hit_c(hit_c),
        .hit_h(hit_h),
        .hit_t(hit_t),
        .smm_dram(smm_dram),
        .seg_base(seg_base)
    );

    // Legacy video precedence
    smd_vga_route u_vga (
        .addr(req_addr),
        .pcmd(s.pcmd),
        .in_vga(v_in),
        .tgt(v_tgt)
    );

    // Bus and output handshakes
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = s.prdata;
    assign req_ready = !s.spl && (!s.ov || out_ready);
    assign acc = req_valid && req_ready && ce;
    assign out_valid = s.ov;
    assign out_tgt = s.tgt;
    assign out_addr = s.oaddr;
    assign out_be = s.obe;
    assign out_write = s.ow;
    assign out_ur = s.our;
    assign out_posted = s.opost;
    assign out_snoop = s.osnp;
    assign invalid_translation_flag = s.itf;

    // Register read mux and address map
    always_comb
    begin
        mapped = 1'b1;
        rdv = `SMD_RST_WORD;
        case (paddr)
            `SMD_REG_CTRL: rdv = {24'h000000, s.ctrl};
            `SMD_REG_MEMTOP: rdv = s.memtop;
            `SMD_REG_STOLEN: rdv = s.stolen;
            `SMD_REG_IOWIN: rdv = s.iowin;
            `SMD_REG_PCMD: rdv = {28'h0000000, s.pcmd};
            `SMD_REG_AP_LO: rdv = s.ap_lo;
            `SMD_REG_AP_HI: rdv = s.ap_hi;
            `SMD_REG_ERR: rdv = {31'h00000000, s.itf};
            `SMD_REG_STAT: rdv = {27'h0000000, s.spl, s.ov, s.tgt};
            default: mapped = 1'b0;
        endcase
    end

    // Request decode, settled in the accepting cycle
    always_comb
    begin
        t = SMD_TGT_DMI;
        a = {req_addr[31:3], 3'b000};
        be = req_be[3:0];
        w = req_write;
        ur = 1'b0;
        snp = 1'b0;
        setf = 1'b0;
        split = 1'b0;
        in_ap = smd_in(req_addr, s.ap_lo, s.ap_hi);
        io_hit = req_addr[15:0] >= s.iowin[15:0] && req_addr[15:0] <= s.iowin[31:16];
        grant = (req_write && !request_type_bit)
            || (s.ctrl[`SMD_CTRL_OPEN] && !s.ctrl[`SMD_CTRL_LCK])
            || (req_smm && (req_code || !s.ctrl[`SMD_CTRL_CLS]));
        if (req_be[3:0] == 4'h0)
        begin
            a = {req_addr[31:3], 3'b000} + `SMD_DW_OFS;
            be = req_be[7:4];
        end
        if (req_kind == SMD_K_FETCH)
        begin
            t = SMD_TGT_DRAM;
            a = req_addr;
            if (req_addr >= seg_base || smd_in(req_addr, `SMD_COMPAT_LO, `SMD_LEGACY_HI))
                a = `SMD_NULL_ADDR;
        end
        else if (req_src == SMD_SRC_CPU)
        begin
            if (req_kind == SMD_K_CFG)
                t = SMD_TGT_INT;
            else if (req_kind == SMD_K_IO)
            begin
                a = {15'h0000, a[16:0]};
                t = (s.pcmd[`SMD_PCMD_IOEN] && io_hit) ? SMD_TGT_PCIE : SMD_TGT_DMI;
                if (!req_write && req_be[3:0] != 4'h0 && req_be[7:4] != 4'h0)
                    split = 1'b1;
            end
            else if (hit_c || hit_h || hit_t)
            begin
                if (grant)
                begin
                    t = SMD_TGT_DRAM;
                    if (hit_h)
                        a = a - `SMD_HIGH_LO + `SMD_COMPAT_LO;
                end
                else if (hit_c)
                    t = v_tgt;
                else if (req_smm && s.ctrl[`SMD_CTRL_CLS])
                    t = SMD_TGT_DMI;
                else
                    t = SMD_TGT_ABORT;
            end
            else if (v_in)
                t = v_tgt;
            else if (in_ap)
                t = SMD_TGT_IGD;
            else if (req_addr < s.memtop)
                t = SMD_TGT_DRAM;
        end
        else if (req_src == SMD_SRC_GFX)
        begin
            t = SMD_TGT_DRAM;
            if (smm_dram || hit_h)
            begin
                a = `SMD_NULL_ADDR;
                setf = 1'b1;
                if (req_write)
                    be = 4'h0;
            end
        end
        else
        begin
            if (req_kind != SMD_K_MEM)
            begin
                t = SMD_TGT_DRAM;
                a = `SMD_NULL_ADDR;
                w = 1'b0;
                ur = 1'b1;
            end
            else if (in_ap)
            begin
                t = SMD_TGT_IGD;
                snp = req_write;
                if (!req_write)
                begin
                    t = SMD_TGT_DRAM;
                    a = `SMD_NULL_ADDR;
                    ur = 1'b1;
                end
            end
            else if (smm_dram || hit_h)
            begin
                t = SMD_TGT_DRAM;
                a = `SMD_NULL_ADDR;
                be = 4'h0;
                ur = !req_write;
            end
            else if (req_addr < s.memtop)
                t = SMD_TGT_DRAM;
        end
    end

    // Next state: registers, output stage, split tail
    always_comb
    begin
        next_s = s;
        if (psel && !penable)
            next_s.prdata = rdv;
        if (psel && penable && pwrite)
        begin
            case (paddr)
                `SMD_REG_CTRL:
                begin
                    if (s.ctrl[`SMD_CTRL_LCK])
                        next_s.ctrl[`SMD_CTRL_CLS] = pwdata[`SMD_CTRL_CLS];
                    else
                        next_s.ctrl = pwdata[7:0];
                end
                `SMD_REG_MEMTOP: next_s.memtop = pwdata;
                `SMD_REG_STOLEN: next_s.stolen = pwdata;
                `SMD_REG_IOWIN: next_s.iowin = pwdata;
                `SMD_REG_PCMD: next_s.pcmd = pwdata[3:0];
                `SMD_REG_AP_LO: next_s.ap_lo = pwdata;
                `SMD_REG_AP_HI: next_s.ap_hi = pwdata;
                `SMD_REG_ERR:
                    if (pwdata[`SMD_ERR_ITF])
                        next_s.itf = 1'b0;
                default: ;
            endcase
        end
        // Hardware set wins over the clear
        if (acc && setf)
            next_s.itf = 1'b1;
        if (s.ov && out_ready)
            next_s.ov = 1'b0;
        if (s.spl && (!s.ov || out_ready))
        begin
            next_s.ov = 1'b1;
            next_s.oaddr = s.saddr;
            next_s.obe = s.sbe;
            next_s.spl = 1'b0;
        end
        else if (acc)
        begin
            next_s.ov = 1'b1;
            next_s.tgt = t;
            next_s.oaddr = a;
            next_s.obe = be;
            next_s.ow = w;
            next_s.our = ur;
            next_s.osnp = snp;
            next_s.opost = w && req_kind == SMD_K_MEM
                && (t == SMD_TGT_DMI || t == SMD_TGT_PCIE);
            next_s.spl = split;
            next_s.saddr = a + `SMD_DW_OFS;
            next_s.sbe = req_be[7:4];
        end
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.ctrl <= `SMD_RST_CTRL;
        end
        else if (ce)
            s <= next_s;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_high_remap;
        acc && req_src == SMD_SRC_CPU && req_kind == SMD_K_MEM && hit_h && req_smm && req_code
        |=> out_tgt == SMD_TGT_DRAM && out_addr[31:17] == 15'h0005;
    endproperty
    a_high_remap: assert property (p_high_remap)
        else $error("high window not remapped");

    property p_down_deny;
        acc && (req_src == SMD_SRC_PCIE || req_src == SMD_SRC_DMI)
        && req_kind == SMD_K_MEM && smm_dram && !in_ap
        |=> out_addr == `SMD_NULL_ADDR && out_be == 4'h0;
    endproperty
    a_down_deny: assert property (p_down_deny)
        else $error("downstream reached SMM");

    property p_lock_deny;
        acc && req_src == SMD_SRC_CPU && req_kind == SMD_K_MEM && hit_h && !req_smm
        && request_type_bit && s.ctrl[`SMD_CTRL_LCK]
        |=> out_tgt == SMD_TGT_ABORT;
    endproperty
    a_lock_deny: assert property (p_lock_deny)
        else $error("locked access not terminated");

    property p_wb;
        acc && req_src == SMD_SRC_CPU && req_kind == SMD_K_MEM && req_write
        && !request_type_bit && (hit_c || hit_h || hit_t) |=> out_tgt == SMD_TGT_DRAM;
    endproperty
    a_wb: assert property (p_wb)
        else $error("write-back not sent to DRAM");

    property p_gfx;
        acc && req_src == SMD_SRC_GFX && req_kind == SMD_K_MEM && smm_dram && req_write
        |=> out_addr == `SMD_NULL_ADDR && out_be == 4'h0 && invalid_translation_flag;
    endproperty
    a_gfx: assert property (p_gfx)
        else $error("graphics SMM hit not redirected");

    property p_io_off;
        acc && req_src == SMD_SRC_CPU && req_kind == SMD_K_IO && !s.pcmd[`SMD_PCMD_IOEN]
        |=> out_tgt == SMD_TGT_DMI;
    endproperty
    a_io_off: assert property (p_io_off)
        else $error("I/O routed to disabled port");

    property p_up_io;
        acc && req_src == SMD_SRC_DMI && req_kind == SMD_K_IO
        |=> out_ur && !out_write && out_addr == `SMD_NULL_ADDR;
    endproperty
    a_up_io: assert property (p_up_io)
        else $error("upstream I/O not turned to read");

    property p_split;
        acc && split ##1 out_ready && ce |=> out_valid && out_be == $past(s.sbe);
    endproperty
    a_split: assert property (p_split)
        else $error("split tail not issued");

    c_split: cover property (acc && split ##1 out_valid ##[1:4] out_valid && !s.spl);
    c_remap: cover property (acc && hit_h && req_smm);
    c_flag: cover property ($rose(invalid_translation_flag));
endmodule : smd_decoder

/* File: smd_pkg.sv */
package smd_pkg;
    typedef enum logic [2:0] {
        SMD_TGT_DRAM = 3'h0,
        SMD_TGT_DMI = 3'h1,
        SMD_TGT_PCIE = 3'h2,
        SMD_TGT_IGD = 3'h3,
        SMD_TGT_INT = 3'h4,
        SMD_TGT_ABORT = 3'h5
    } smd_tgt_t;
    typedef enum logic [1:0] {
        SMD_SRC_CPU = 2'h0,
        SMD_SRC_PCIE = 2'h1,
        SMD_SRC_DMI = 2'h2,
        SMD_SRC_GFX = 2'h3
    } smd_src_t;
    typedef enum logic [1:0] {
        SMD_K_MEM = 2'h0,
        SMD_K_IO = 2'h1,
        SMD_K_CFG = 2'h2,
        SMD_K_FETCH = 2'h3
    } smd_kind_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [31:0] memtop;
        logic [31:0] stolen;
        logic [31:0] iowin;
        logic [3:0] pcmd;
        logic [31:0] ap_lo;
        logic [31:0] ap_hi;
        logic itf;
        logic [31:0] prdata;
        logic ov;
        smd_tgt_t tgt;
        logic [31:0] oaddr;
        logic [3:0] obe;
        logic ow;
        logic our;
        logic opost;
        logic osnp;
        logic spl;
        logic [31:0] saddr;
        logic [3:0] sbe;
    } smd_st_t;
    // Inclusive address range check
    function automatic logic smd_in(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : smd_in
endpackage : smd_pkg

/* File: smd_sink.sv */
`timescale 1ns/1ps
module smd_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    output logic out_ready
);
    logic [1:0] cnt;
    // Takes every output, or one in four cycles when slow
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 2'h0;
            out_ready <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 2'h1;
            out_ready <= !slow || (cnt == 2'h3);
        end
    end
endmodule : smd_sink

/* File: smd_vga_route.sv */
`timescale 1ns/1ps
`include "smd_cfg.svh"
module smd_vga_route
    import smd_pkg::*;
(
    input wire logic [31:0] addr,
    input wire logic [3:0] pcmd,
    output logic in_vga,
    output smd_tgt_t tgt
);
    logic mono;
    assign in_vga = smd_in(addr, `SMD_COMPAT_LO, `SMD_COMPAT_HI);
    assign mono = smd_in(addr, `SMD_MONO_LO, `SMD_MONO_HI);
    // Integrated graphics first, then port, then downstream
    always_comb
    begin
        if (pcmd[`SMD_PCMD_IGD])
            tgt = SMD_TGT_IGD;
        else if (pcmd[`SMD_PCMD_VID] && !(pcmd[`SMD_PCMD_MONO] && mono))
            tgt = SMD_TGT_PCIE;
        else
            tgt = SMD_TGT_DMI;
    end
endmodule : smd_vga_route

/* File: smd_window.sv */
`timescale 1ns/1ps
`include "smd_cfg.svh"
module smd_window
    import smd_pkg::*;
(
    input wire logic [31:0] addr,
    input wire logic [7:0] ctrl,
    input wire logic [31:0] memtop,
    input wire logic [31:0] stolen,
    input wire logic [1:0] seg_size,
    output logic hit_c,
    output logic hit_h,
    output logic hit_t,
    output logic smm_dram,
    output logic [31:0] seg_base
);
    logic ge;
    logic [31:0] sz;
    logic [31:0] top;
    logic in_c;
    // Segment size choice
    always_comb
    begin
        case (seg_size)
            2'h0: sz = `SMD_SEG_1M;
            2'h1: sz = `SMD_SEG_2M;
            default: sz = `SMD_SEG_8M;
        endcase
    end
    // Window hits under the enable table
    assign ge = ctrl[`SMD_CTRL_GE];
    assign top = memtop - stolen;
    assign seg_base = top - sz;
    assign in_c = smd_in(addr, `SMD_COMPAT_LO, `SMD_COMPAT_HI);
    assign hit_c = ge && !ctrl[`SMD_CTRL_HEN] && in_c;
    assign hit_h = ge && ctrl[`SMD_CTRL_HEN] && smd_in(addr, `SMD_HIGH_LO, `SMD_HIGH_HI);
    assign hit_t = ge && ctrl[`SMD_CTRL_TEN] && addr >= seg_base && addr < top;
    // SMM DRAM: compatible DRAM backs both low and high windows
    assign smm_dram = hit_t || (ge && in_c);
endmodule : smd_window

/* File: smm_space_and_io_decoder_tb.sv */
`timescale 1ns/1ps
`include "smd_cfg.svh"
module smm_space_and_io_decoder_tb
    import smd_pkg::*;
();
    logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, slow;
    logic [7:0] paddr, req_be;
    logic [31:0] pwdata, prdata, req_addr, out_addr, lfsr_v;
    logic req_valid, req_ready, req_write, req_smm, req_code, request_type_bit;
    logic out_valid, out_ready, out_write, out_ur, out_posted, out_snoop;
    logic invalid_translation_flag;
    logic [3:0] out_be;
    smd_src_t req_src;
    smd_kind_t req_kind;
    smd_tgt_t out_tgt;
    typedef struct packed {
        logic [3:0] m;
        smd_tgt_t tgt;
        logic [31:0] addr;
        logic [3:0] be;
        logic [3:0] wup;
    } smd_exp_t;
    smd_exp_t expq[$];
    int failures, tests_run;

    smd_decoder dut_u (.clk, .rst_n, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .req_valid, .req_ready, .req_src, .req_kind, .req_addr, .req_write,
        .req_be, .req_smm, .req_code, .request_type_bit, .out_valid, .out_ready, .out_tgt,
        .out_addr, .out_be, .out_write, .out_ur, .out_posted, .out_snoop,
        .invalid_translation_flag);
    smd_sink sink_u (.clk, .rst_n, .slow, .out_ready);

    // Free-running bench clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic hang(input string what);
        failures++;
        $display("BAD at %0t %s hung %h %h", $time, what, 32'h1, 32'h0);
        finish_test();
    endtask : hang

    task automatic chk_out(input smd_exp_t e);
        logic [42:0] g, x, k;
        g = {out_tgt, out_addr, out_be, out_snoop, out_write, out_ur, out_posted};
        x = {e.tgt, e.addr, e.be, e.wup};
        k = {{3{e.m[0]}}, {32{e.m[1]}}, {4{e.m[2]}}, {4{e.m[3]}}};
        tests_run++;
        if ((g & k) !== (x & k))
        begin
            failures++;
            $display("BAD at %0t out got %h expected %h", $time, g & k, x & k);
        end
    endtask : chk_out

    task automatic chk_reg(input logic [32:0] g, input logic [32:0] x);
        tests_run++;
        if (g !== x)
        begin
            failures++;
            $display("BAD at %0t reg got %h expected %h", $time, g, x);
        end
    endtask : chk_reg

    // Each accepted output is checked against the oldest expectation
    always @(posedge clk)
    begin
        if (rst_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
        begin
            if (expq.size() == 0)
            begin
                failures++;
                $display("BAD at %0t stray output %h expected %h", $time, out_addr, 32'h0);
            end
            else
                chk_out(expq.pop_front());
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [32:0] r);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (i >= 20)
            hang("apb");
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [32:0] x);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        chk_reg(r, x);
    endtask : rdc

    task automatic exp(input logic [3:0] m, input smd_tgt_t t, input logic [31:0] a,
                       input logic [3:0] b, input logic [3:0] w);
        expq.push_back('{m, t, a, b, w});
    endtask : exp

    // Flags are write, in SMM, code fetch, write-back
    task automatic req(input smd_src_t s, input smd_kind_t k, input logic [31:0] a,
                       input logic [7:0] b, input logic [3:0] f);
        int i;
        @(posedge clk);
        req_valid <= 1'b1;
        req_src <= s;
        req_kind <= k;
        req_addr <= a;
        req_be <= b;
        {req_write, req_smm, req_code} <= f[3:1];
        request_type_bit <= !f[0];
        slow <= lfsr_v[0];
        lfsr_v = lfsr(lfsr_v);
        i = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && i < 40)
        begin
            @(negedge clk);
            i++;
        end
        if (i >= 40)
            hang("request");
        @(posedge clk);
        req_valid <= 1'b0;
    endtask : req

    task automatic drain(input string what);
        int i;
        for (i = 0; i < 200 && expq.size() != 0; i++)
            @(posedge clk);
        if (expq.size() != 0)
            hang(what);
        $display("test %s done", what);
    endtask : drain

    // Main sequence
    initial
    begin
        int n;
        logic [1:0] s;
        logic [31:0] ra, sz;
        smd_tgt_t tv;
        {psel, penable, pwrite, req_valid, req_write, req_smm, req_code, slow} = '0;
        {ce, request_type_bit, rst_n} = 3'h6;
        {paddr, req_be, pwdata, req_addr} = '0;
        req_src = SMD_SRC_CPU;
        req_kind = SMD_K_MEM;
        lfsr_v = 32'h479D;
        failures = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`SMD_REG_CTRL, 33'h0);
        rdc(8'h24, 33'h1_0000_0000);
        exp(4'h1, SMD_TGT_DMI, 0, 0, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h4);
        wr(`SMD_REG_CTRL, 32'h01);
        exp(4'h7, SMD_TGT_DRAM, `SMD_COMPAT_LO, 4'hF, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h4);
        exp(4'h1, SMD_TGT_DMI, 0, 0, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h0);
        for (n = 0; n < 6; n++)
        begin
            ra = `SMD_COMPAT_LO + (lfsr_v & 32'h0001_FFF8);
            exp(4'h7, SMD_TGT_DRAM, ra, 4'hF, 0);
            req(SMD_SRC_CPU, SMD_K_MEM, ra, 8'h0F, 4'h4);
        end
        exp(4'hA, SMD_TGT_DRAM, 0, 0, 3'h2);
        req(SMD_SRC_PCIE, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h4);
        exp(4'h6, SMD_TGT_DRAM, 0, 0, 0);
        req(SMD_SRC_GFX, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h8);
        exp(4'h2, SMD_TGT_DRAM, 0, 0, 0);
        req(SMD_SRC_CPU, SMD_K_FETCH, 32'h000C_0000, 8'h0F, 4'h0);
        drain("compatible");
        chk_reg({32'h0, invalid_translation_flag}, 33'h1);
        rdc(`SMD_REG_ERR, 33'h1);
        wr(`SMD_REG_ERR, 32'h1);
        rdc(`SMD_REG_ERR, 33'h0);
        wr(`SMD_REG_CTRL, 32'h09);
        exp(4'h7, SMD_TGT_DRAM, `SMD_COMPAT_LO, 4'hF, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h0);
        wr(`SMD_REG_CTRL, 32'h11);
        exp(4'h1, SMD_TGT_DMI, 0, 0, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h4);
        exp(4'h7, SMD_TGT_DRAM, `SMD_COMPAT_LO, 4'hF, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h6);
        wr(`SMD_REG_CTRL, 32'h03);
        exp(4'h7, SMD_TGT_DRAM, 32'h000A_0100, 4'hF, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, 32'hFEDA_0100, 8'h0F, 4'h6);
        exp(4'h1, SMD_TGT_ABORT, 0, 0, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, 32'hFEDA_0100, 8'h0F, 4'h0);
        exp(4'h7, SMD_TGT_DRAM, 32'h000A_0100, 4'hF, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, 32'hFEDA_0100, 8'h0F, 4'h9);
        exp(4'h1, SMD_TGT_DMI, 0, 0, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h4);
        wr(`SMD_REG_PCMD, 32'h2);
        exp(4'h1, SMD_TGT_PCIE, 0, 0, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h4);
        drain("high");
        wr(`SMD_REG_MEMTOP, 32'h1000_0000);
        wr(`SMD_REG_STOLEN, 32'h0100_0000);
        for (s = 0; s < 3; s++)
        begin
            sz = (s == 0) ? `SMD_SEG_1M : (s == 1) ? `SMD_SEG_2M : `SMD_SEG_8M;
            ra = 32'h0F00_0000 - sz;
            wr(`SMD_REG_CTRL, {24'h0, s, 6'h05});
            exp(4'h7, SMD_TGT_DRAM, ra, 4'hF, 0);
            req(SMD_SRC_CPU, SMD_K_MEM, ra, 8'h0F, 4'h4);
            exp(4'h1, SMD_TGT_ABORT, 0, 0, 0);
            req(SMD_SRC_CPU, SMD_K_MEM, ra, 8'h0F, 4'h0);
            exp(4'h1, SMD_TGT_DRAM, 0, 0, 0);
            req(SMD_SRC_CPU, SMD_K_MEM, ra - 32'h8, 8'h0F, 4'h0);
        end
        drain("segment");
        wr(`SMD_REG_CTRL, 32'h0);
        wr(`SMD_REG_IOWIN, 32'h1FFF_1000);
        wr(`SMD_REG_PCMD, 32'h1);
        exp(4'hF, SMD_TGT_PCIE, 32'h1000, 4'hF, 0);
        req(SMD_SRC_CPU, SMD_K_IO, 32'h1000, 8'h0F, 4'h0);
        exp(4'hF, SMD_TGT_DMI, 32'h3000, 4'hF, 3'h4);
        req(SMD_SRC_CPU, SMD_K_IO, 32'h3000, 8'h0F, 4'h8);
        exp(4'hF, SMD_TGT_PCIE, 32'h1000, 4'h8, 0);
        exp(4'hF, SMD_TGT_PCIE, 32'h1004, 4'h1, 0);
        req(SMD_SRC_CPU, SMD_K_IO, 32'h1000, 8'h18, 4'h0);
        exp(4'h7, SMD_TGT_DMI, 32'h0001_0000, 4'h7, 0);
        req(SMD_SRC_CPU, SMD_K_IO, 32'h0001_0000, 8'h07, 4'h0);
        wr(`SMD_REG_PCMD, 32'h0);
        exp(4'h7, SMD_TGT_DMI, 32'h1000, 4'hF, 0);
        req(SMD_SRC_CPU, SMD_K_IO, 32'h1000, 8'h0F, 4'h0);
        exp(4'h9, SMD_TGT_DMI, 0, 0, 3'h5);
        req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h8);
        exp(4'hA, SMD_TGT_DRAM, 0, 0, 3'h2);
        req(SMD_SRC_DMI, SMD_K_IO, 32'h3000, 8'h0F, 4'h8);
        exp(4'hA, SMD_TGT_DRAM, 0, 0, 3'h2);
        req(SMD_SRC_PCIE, SMD_K_CFG, 32'h3000, 8'h0F, 4'h0);
        wr(`SMD_REG_AP_HI, 32'h3FFF);
        exp(4'hF, SMD_TGT_IGD, 32'h3000, 4'hF, 4'hC);
        req(SMD_SRC_PCIE, SMD_K_MEM, 32'h3000, 8'h0F, 4'h8);
        for (n = 0; n < 3; n++)
        begin
            tv = (n == 0) ? SMD_TGT_IGD : (n == 1) ? SMD_TGT_PCIE : SMD_TGT_DMI;
            wr(`SMD_REG_PCMD, (n == 0) ? 32'h8 : (n == 1) ? 32'h2 : 32'h0);
            exp(4'h1, tv, 0, 0, 0);
            req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h0);
        end
        drain("io");
        wr(`SMD_REG_CTRL, 32'h2B);
        exp(4'h1, SMD_TGT_ABORT, 0, 0, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, 32'hFEDA_0100, 8'h0F, 4'h0);
        exp(4'h7, SMD_TGT_DRAM, 32'h000A_0100, 4'hF, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, 32'hFEDA_0100, 8'h0F, 4'h4);
        wr(`SMD_REG_CTRL, 32'h0);
        rdc(`SMD_REG_CTRL, 33'h2B);
        drain("lock");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`SMD_REG_CTRL, 33'h0);
        exp(4'h1, SMD_TGT_DMI, 0, 0, 0);
        req(SMD_SRC_CPU, SMD_K_MEM, `SMD_COMPAT_LO, 8'h0F, 4'h4);
        drain("reset");
        finish_test();
    end
endmodule : smm_space_and_io_decoder_tb
